//--- hw/wdr_defines.vh
// Shared constants for the watchdog with reload lock
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH

// Register select codes on reg_sel_i
`define WDR_SEL_CTL      3'h0
`define WDR_SEL_UPPER    3'h1
`define WDR_SEL_HIGH     3'h2
`define WDR_SEL_LOW      3'h3
`define WDR_SEL_OTHER    3'h4

// Unlock bytes written to the control address
`define WDR_UNLOCK_1     8'h55
`define WDR_UNLOCK_2     8'haa

// Reset values
`define WDR_RELOAD_RST   24'h000400
`define WDR_CTL_RST      8'h00

// Reset cause register field positions
`define WDR_CAUSE_WDOG   1
`define WDR_CAUSE_STOP   0

// Lock state codes
`define WDR_LK_LOCKED    3'h0
`define WDR_LK_GOT1      3'h1
`define WDR_LK_WANT_U    3'h2
`define WDR_LK_WANT_H    3'h3
`define WDR_LK_WANT_L    3'h4

`endif

//--- hw/wdr_sync3.v
// Three-flop synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module wdr_sync3 (
   input  wire sys_clk_i,
   input  wire rst_n_i,
   input  wire async_i,
   output wire level_o,
   output wire rise_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg level_q;
   reg rise_q;

   // The first stage feeds only the second, to contain metastability
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
      end else begin
         s1_q   <= async_i;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         rise_q <= 1'b0;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
            rise_q  <= s3_q & ~level_q;
         end
      end
   end

   assign level_o = level_q;
   assign rise_o  = rise_q;
endmodule // wdr_sync3

//--- hw/wdr_watchdog.v
// Watchdog counter with time-out reset, stop recovery and reload write lock
`timescale 1ns/1ps
`include "wdr_defines.vh"
module wdr_watchdog (
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   input  wire        reg_wr_i,
   input  wire [2:0]  reg_sel_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        watchdog_enable_i,
   input  wire        watchdog_refresh_i,
   input  wire        stop_mode_i,
   input  wire        timeout_reset_select_i,
   input  wire        watchdog_osc_i,
   input  wire        reset_cause_clr_i,
   output wire [7:0]  watchdog_control_o,
   output wire [7:0]  reload_upper_byte_o,
   output wire [7:0]  reload_high_byte_o,
   output wire [7:0]  reload_low_byte_o,
   output wire [23:0] count_o,
   output wire        unlocked_o,
   output wire [1:0]  reset_cause_register_o,
   output wire        timeout_o,
   output wire        sys_reset_o,
   output wire        stop_recovery_o
);
   localparam [2:0] LK_LOCKED = `WDR_LK_LOCKED;
   localparam [2:0] LK_GOT1   = `WDR_LK_GOT1;
   localparam [2:0] LK_WANT_U = `WDR_LK_WANT_U;
   localparam [2:0] LK_WANT_H = `WDR_LK_WANT_H;
   localparam [2:0] LK_WANT_L = `WDR_LK_WANT_L;
   localparam [23:0] RELOAD_RST = `WDR_RELOAD_RST;

   reg  [2:0]  lock_q;
   reg  [2:0]  lock_d;
   reg  [7:0]  ctl_q;
   reg  [7:0]  upper_q;
   reg  [7:0]  high_q;
   reg  [7:0]  low_q;
   reg  [23:0] cnt_q;
   reg         en_q;
   reg         cause_wdog_q;
   reg         cause_stop_q;
   reg         timeout_q;
   reg         sys_reset_q;
   reg         stop_rec_q;
   wire        osc_tick;
   wire        ctl_wr;
   wire        is_unlock1;
   wire        is_unlock2;
   wire        wr_upper;
   wire        wr_high;
   wire        wr_low;
   wire        expire;
   wire        fire_reset;
   wire [23:0] reload_val;

   // Write to a given register select
   function sel_hit;
      input       wr;
      input [2:0] sel;
      input [2:0] want;
      begin
         sel_hit = wr & (sel == want);
      end
   endfunction

   // Oscillator comes from its own domain, so it is synchronised first
   wdr_sync3 u_osc_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   (watchdog_osc_i),
      .level_o   (),
      .rise_o    (osc_tick)
   );

   assign ctl_wr     = sel_hit(reg_wr_i, reg_sel_i, `WDR_SEL_CTL);
   assign is_unlock1 = ctl_wr & (reg_wdata_i == `WDR_UNLOCK_1);
   assign is_unlock2 = ctl_wr & (reg_wdata_i == `WDR_UNLOCK_2);
   assign wr_upper   = sel_hit(reg_wr_i, reg_sel_i, `WDR_SEL_UPPER) & (lock_q == LK_WANT_U);
   assign wr_high    = sel_hit(reg_wr_i, reg_sel_i, `WDR_SEL_HIGH) & (lock_q == LK_WANT_H);
   assign wr_low     = sel_hit(reg_wr_i, reg_sel_i, `WDR_SEL_LOW) & (lock_q == LK_WANT_L);
   assign reload_val = {upper_q, high_q, low_q};

   // Lock state machine
   always @* begin
      lock_d = lock_q;
      if (reg_wr_i) begin
         case (lock_q)
            LK_GOT1: begin
               if (is_unlock2) begin
                  lock_d = LK_WANT_U;
               end else if (is_unlock1) begin
                  lock_d = LK_GOT1;
               end else begin
                  lock_d = LK_LOCKED;
               end
            end
            LK_WANT_U: begin
               if (wr_upper) begin
                  lock_d = LK_WANT_H;
               end else if (is_unlock1) begin
                  lock_d = LK_GOT1;
               end else begin
                  lock_d = LK_LOCKED;
               end
            end
            LK_WANT_H: begin
               if (wr_high) begin
                  lock_d = LK_WANT_L;
               end else if (is_unlock1) begin
                  lock_d = LK_GOT1;
               end else begin
                  lock_d = LK_LOCKED;
               end
            end
            LK_WANT_L: begin
               // Low byte closes the window again
               if (is_unlock1) begin
                  lock_d = LK_GOT1;
               end else begin
                  lock_d = LK_LOCKED;
               end
            end
            default: begin
               if (is_unlock1) begin
                  lock_d = LK_GOT1;
               end else begin
                  lock_d = LK_LOCKED;
               end
            end
         endcase
      end
   end

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_q <= LK_LOCKED;
      end else begin
         lock_q <= lock_d;
      end
   end

   // Control and reload byte registers
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q   <= `WDR_CTL_RST;
         upper_q <= RELOAD_RST[23:16];
         high_q  <= RELOAD_RST[15:8];
         low_q   <= RELOAD_RST[7:0];
      end else begin
         // Unlock bytes do not land in control
         if (ctl_wr && !is_unlock1 && !is_unlock2) begin
            ctl_q <= reg_wdata_i;
         end
         if (wr_upper) begin
            upper_q <= reg_wdata_i;
         end
         if (wr_high) begin
            high_q <= reg_wdata_i;
         end
         if (wr_low) begin
            low_q <= reg_wdata_i;
         end
      end
   end

   // Expire on the tick that reaches zero
   assign expire     = en_q & osc_tick & (cnt_q <= 24'h000001);
   assign fire_reset = expire & timeout_reset_select_i;

   // Counter; it reloads after a time-out so a non-reset time-out repeats
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q  <= 1'b0;
         cnt_q <= 24'h000000;
      end else begin
         en_q <= watchdog_enable_i;
         // Load on first enable or refresh
         if ((watchdog_enable_i && !en_q) || (watchdog_refresh_i && en_q)) begin
            cnt_q <= reload_val;
         end else if (expire) begin
            cnt_q <= reload_val;
         end else if (en_q && osc_tick) begin
            cnt_q <= cnt_q - 24'h000001;
         end
      end
   end

   // Time-out actions and reset cause flags; a set wins over a clear
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_wdog_q <= 1'b0;
         cause_stop_q <= 1'b0;
         timeout_q    <= 1'b0;
         sys_reset_q  <= 1'b0;
         stop_rec_q   <= 1'b0;
      end else begin
         timeout_q   <= expire;
         sys_reset_q <= fire_reset & ~stop_mode_i;
         stop_rec_q  <= fire_reset & stop_mode_i;
         if (reset_cause_clr_i) begin
            cause_wdog_q <= 1'b0;
            cause_stop_q <= 1'b0;
         end
         if (fire_reset) begin
            cause_wdog_q <= 1'b1;
         end
         if (fire_reset && stop_mode_i) begin
            cause_stop_q <= 1'b1;
         end
      end
   end

   assign watchdog_control_o     = ctl_q;
   assign reload_upper_byte_o    = upper_q;
   assign reload_high_byte_o     = high_q;
   assign reload_low_byte_o      = low_q;
   assign count_o                = cnt_q;
   assign unlocked_o             = (lock_q == LK_WANT_U) | (lock_q == LK_WANT_H) |
                                   (lock_q == LK_WANT_L);
   assign reset_cause_register_o = {cause_wdog_q, cause_stop_q};
   assign timeout_o              = timeout_q;
   assign sys_reset_o            = sys_reset_q;
   assign stop_recovery_o        = stop_rec_q;
endmodule // wdr_watchdog

//--- tb/wdr_watchdog_props.sv
// Checker for the watchdog port behaviour
`timescale 1ns/1ps
`include "wdr_defines.vh"
module wdr_watchdog_props (
   input wire        sys_clk_i,
   input wire        rst_n_i,
   input wire        reg_wr_i,
   input wire [2:0]  reg_sel_i,
   input wire [7:0]  reg_wdata_i,
   input wire        watchdog_enable_i,
   input wire        watchdog_refresh_i,
   input wire        stop_mode_i,
   input wire        timeout_reset_select_i,
   input wire        watchdog_osc_i,
   input wire        reset_cause_clr_i,
   input wire [7:0]  watchdog_control_o,
   input wire [7:0]  reload_upper_byte_o,
   input wire [7:0]  reload_high_byte_o,
   input wire [7:0]  reload_low_byte_o,
   input wire [23:0] count_o,
   input wire        unlocked_o,
   input wire [1:0]  reset_cause_register_o,
   input wire        timeout_o,
   input wire        sys_reset_o,
   input wire        stop_recovery_o
);
   reg  got55_q;
   reg  want_up_q;
   wire ctl_wr = reg_wr_i && reg_sel_i == `WDR_SEL_CTL;
   wire up_wr  = reg_wr_i && reg_sel_i == `WDR_SEL_UPPER;
   wire [23:0] rl = {reload_upper_byte_o, reload_high_byte_o, reload_low_byte_o};
   // Tracks a pending first unlock byte and an open upper-byte step; any other write drops them
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         got55_q   <= 1'b0;
         want_up_q <= 1'b0;
      end else if (reg_wr_i) begin
         got55_q   <= ctl_wr && reg_wdata_i == `WDR_UNLOCK_1;
         want_up_q <= ctl_wr && reg_wdata_i == `WDR_UNLOCK_2 && got55_q;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   unlock_pair_a: assert property (ctl_wr && reg_wdata_i == `WDR_UNLOCK_2 && got55_q
      |=> unlocked_o) else $error("unlock pair did not open the reload bytes");
   ctl_keep_a: assert property (ctl_wr && (reg_wdata_i == `WDR_UNLOCK_1 ||
      reg_wdata_i == `WDR_UNLOCK_2) |=> $stable(watchdog_control_o)) else $error("control changed");
   upper_take_a: assert property (up_wr && want_up_q
      |=> reload_upper_byte_o == $past(reg_wdata_i)) else $error("upper byte not taken");
   other_relock_a: assert property (reg_wr_i && reg_sel_i == `WDR_SEL_OTHER
      |=> !unlocked_o) else $error("other write did not relock");
   locked_deny_a: assert property (up_wr && !unlocked_o
      |=> $stable(reload_upper_byte_o)) else $error("locked upper byte changed");
   enable_load_a: assert property ($rose(watchdog_enable_i)
      |=> count_o == rl) else $error("enable did not load counter");
   sys_reset_a: assert property (sys_reset_o |-> timeout_o && reset_cause_register_o[1]
      && $past(timeout_reset_select_i) && !$past(stop_mode_i)) else $error("bad system reset");
   stop_recover_a: assert property (timeout_o && $past(timeout_reset_select_i)
      && $past(stop_mode_i) |-> stop_recovery_o && reset_cause_register_o == 2'h3)
      else $error("bad stop recovery");
   no_select_a: assert property (timeout_o && !$past(timeout_reset_select_i)
      |-> !sys_reset_o && !stop_recovery_o) else $error("reset without select");
   expire_load_a: assert property (timeout_o |-> count_o == rl)
      else $error("counter not reloaded at time-out");
endmodule // wdr_watchdog_props
bind wdr_watchdog wdr_watchdog_props chk_i (.*);

//--- tb/wdr_watchdog_test.sv
// Directed bench for the watchdog with reload lock
`timescale 1ns/1ps
`include "wdr_defines.vh"
module wdr_watchdog_test;
   reg         sys_clk_i, rst_n_i, wr, en, rfr, stp, tsel, osc, clr;
   reg  [2:0]  sel;
   reg  [7:0]  wd;
   wire [7:0]  ctl, up, hi, lo;
   wire [23:0] cnt;
   wire [1:0]  cause;
   wire        unl, tmo, srst, srec;
   integer     n_fail, checked, n_rst, n_rec, n_tmo;
   wdr_watchdog uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_sel_i(sel),
      .reg_wdata_i(wd), .watchdog_enable_i(en), .watchdog_refresh_i(rfr), .stop_mode_i(stp),
      .timeout_reset_select_i(tsel), .watchdog_osc_i(osc), .reset_cause_clr_i(clr),
      .watchdog_control_o(ctl), .reload_upper_byte_o(up), .reload_high_byte_o(hi),
      .reload_low_byte_o(lo), .count_o(cnt), .unlocked_o(unl), .reset_cause_register_o(cause),
      .timeout_o(tmo), .sys_reset_o(srst), .stop_recovery_o(srec));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      if (srst === 1'b1) n_rst = n_rst + 1;
      if (srec === 1'b1) n_rec = n_rec + 1;
      if (tmo === 1'b1) n_tmo = n_tmo + 1;
   end
   task give_verdict;
      begin
         if (n_fail == 0 && checked > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // One-cycle write strobe; an idle cycle separates writes
   task wrt(input [2:0] s, input [7:0] d);
      begin
         @(posedge sys_clk_i) #1 wr = 1'b1;
         sel = s;
         wd = d;
         @(posedge sys_clk_i) #1 wr = 1'b0;
      end
   endtask
   task unlock;
      begin
         wrt(`WDR_SEL_CTL, `WDR_UNLOCK_1);
         wrt(`WDR_SEL_CTL, `WDR_UNLOCK_2);
      end
   endtask
   // Slow oscillator edge; wide enough to pass the synchroniser
   task tick;
      begin
         @(posedge sys_clk_i) #1 osc = 1'b1;
         repeat (6) @(posedge sys_clk_i);
         #1 osc = 1'b0;
         repeat (6) @(posedge sys_clk_i);
         #1;
      end
   endtask
   task clear_cause;
      begin
         @(posedge sys_clk_i) #1 clr = 1'b1;
         @(posedge sys_clk_i) #1 clr = 1'b0;
      end
   endtask
   initial begin
      #(40 * 8000);
      n_fail = n_fail + 1;
      give_verdict;
   end
   initial begin
      {wr, en, rfr, stp, tsel, osc, clr, sel, wd} = 0;
      {n_fail, checked, n_rst, n_rec, n_tmo} = 0;
      rst_n_i = 1'b0;
      repeat (20) @(posedge sys_clk_i);
      #1 rst_n_i = 1'b1;
      chk("reload", 24'h000400, {up, hi, lo});
      wrt(`WDR_SEL_CTL, 8'h3c);
      unlock;
      chk("control", 24'h00003c, {16'h0, ctl});
      chk("unlocked", 24'h1, {23'h0, unl});
      wrt(`WDR_SEL_UPPER, 8'h00);
      wrt(`WDR_SEL_HIGH, 8'h00);
      wrt(`WDR_SEL_LOW, 8'h03);
      chk("reload", 24'h000003, {up, hi, lo});
      chk("unlocked", 24'h0, {23'h0, unl});
      wrt(`WDR_SEL_UPPER, 8'h77);
      wrt(`WDR_SEL_LOW, 8'h09);
      chk("reload", 24'h000003, {up, hi, lo});
      unlock;
      wrt(`WDR_SEL_HIGH, 8'h11);
      wrt(`WDR_SEL_UPPER, 8'h22);
      chk("reload", 24'h000003, {up, hi, lo});
      wrt(`WDR_SEL_CTL, `WDR_UNLOCK_1);
      wrt(`WDR_SEL_OTHER, 8'h01);
      wrt(`WDR_SEL_CTL, `WDR_UNLOCK_2);
      chk("unlocked", 24'h0, {23'h0, unl});
      wrt(`WDR_SEL_CTL, `WDR_UNLOCK_2);
      wrt(`WDR_SEL_CTL, `WDR_UNLOCK_1);
      chk("unlocked", 24'h0, {23'h0, unl});
      unlock;
      wrt(`WDR_SEL_UPPER, 8'h00);
      wrt(`WDR_SEL_OTHER, 8'h00);
      wrt(`WDR_SEL_HIGH, 8'h44);
      chk("reload", 24'h000003, {up, hi, lo});
      en = 1'b1;
      tsel = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("count", 24'h000003, cnt);
      tick;
      chk("count", 24'h000002, cnt);
      rfr = 1'b1;
      @(posedge sys_clk_i) #1 rfr = 1'b0;
      chk("count", 24'h000003, cnt);
      repeat (3) tick;
      chk("resets", 24'h1, n_rst[23:0]);
      chk("cause", 24'h2, {22'h0, cause});
      chk("count", 24'h000003, cnt);
      clear_cause;
      stp = 1'b1;
      repeat (3) tick;
      chk("recoveries", 24'h1, n_rec[23:0]);
      chk("cause", 24'h3, {22'h0, cause});
      clear_cause;
      stp = 1'b0;
      tsel = 1'b0;
      repeat (3) tick;
      chk("timeouts", 24'h3, n_tmo[23:0]);
      chk("resets", 24'h1, n_rst[23:0]);
      chk("cause", 24'h0, {22'h0, cause});
      give_verdict;
   end
endmodule // wdr_watchdog_test
